// file: core/lvtx_params.svh
// Constants of the soft serial transmitter: codes, timings and reset values.
//
// Summary of operation
// - Each word leaves most significant bit first.
// - No data until lock asserted and stable.
// - PLL acquires lock after reset, then operates.
// - Static swing setting, 0/1/2, default 2.
// - Internal PLL option serves this instance only.
// - External option takes clocks from input ports.
`ifndef LVTX_PARAMS_SVH
`define LVTX_PARAMS_SVH

// Output swing encodings.
`define LVTX_SWING_LOW     2'h0
`define LVTX_SWING_MEDIUM  2'h1
`define LVTX_SWING_HIGH    2'h2

// System clock period and the least PLL reset pulse, in nanoseconds.
`define LVTX_CLK_PERIOD_NS 100
`define LVTX_PLL_RST_NS    10

// Least reset pulse in cycles, rounded up, never below one.
`define LVTX_PLL_RST_CYC \
   (((`LVTX_PLL_RST_NS + `LVTX_CLK_PERIOD_NS - 1) / `LVTX_CLK_PERIOD_NS) \
    < 1 ? 1 : \
    ((`LVTX_PLL_RST_NS + `LVTX_CLK_PERIOD_NS - 1) / `LVTX_CLK_PERIOD_NS))

// Default lock acquisition and lock settle times, in cycles.
`define LVTX_LOCK_ACQ_CYC    64
`define LVTX_LOCK_STABLE_CYC 16

// Serialization factor and FIFO depth defaults.
`define LVTX_FACTOR     8
`define LVTX_FIFO_DEPTH 16

// Serial line level while idle or not ready.
`define LVTX_IDLE_LEVEL 1'h0

`endif

// file: core/lvtx_pkg.sv
// Types shared by the soft serial transmitter files.
package lvtx_pkg;

   // Start-up sequencer states.
   typedef enum logic [1:0] {
      LVTX_ST_RESET,
      LVTX_ST_ACQUIRE,
      LVTX_ST_SETTLE,
      LVTX_ST_RUN
   } lvtx_state_t;

   // Status seen by the fabric logic.
   typedef struct packed {
      logic pll_locked;   // Lock indication currently high.
      logic ser_ready;    // Lock was stable; serial stages run.
   } lvtx_status_t;

endpackage

// file: core/lvtx_fifo.sv
// Parameterised word FIFO standing in front of the serializer.
`timescale 1ns/1ps
module lvtx_fifo #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 16
) (
   // Clock and reset.
   input  wire logic             clk,
   input  wire logic             rst_n,
   // Fill side.
   input  wire logic [WIDTH-1:0] wr_data,
   input  wire logic             wr_valid,
   output logic                  wr_ready,
   // Drain side.
   output logic [WIDTH-1:0]      rd_data,
   output logic                  rd_valid,
   input  wire logic             rd_ready
);
   localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [WIDTH-1:0] mem_q [DEPTH];  // Storage array.
   logic [AW-1:0]    wptr_q, wptr_d; // Write index.
   logic [AW-1:0]    rptr_q, rptr_d; // Read index.
   logic [AW:0]      cnt_q, cnt_d;   // Words held.
   logic             push, pop;

   // Honest flags straight from the fill count.
   assign wr_ready = (cnt_q != (AW+1)'(DEPTH));
   assign rd_valid = (cnt_q != '0);
   assign rd_data  = mem_q[rptr_q];
   assign push     = wr_valid && wr_ready;
   assign pop      = rd_valid && rd_ready;

   // Pointer and count next values; indices wrap at DEPTH.
   always_comb begin
      wptr_d = wptr_q;
      rptr_d = rptr_q;
      if (push) begin
         wptr_d = (wptr_q == AW'(DEPTH-1)) ? '0 : wptr_q + 1'b1;
      end
      if (pop) begin
         rptr_d = (rptr_q == AW'(DEPTH-1)) ? '0 : rptr_q + 1'b1;
      end
      cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
   end

   // Pointer registers.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wptr_q <= '0;
         rptr_q <= '0;
         cnt_q  <= '0;
      end else begin
         wptr_q <= wptr_d;
         rptr_q <= rptr_d;
         cnt_q  <= cnt_d;
      end
   end

   // Storage has no reset; only written words are ever read.
   always_ff @(posedge clk) begin
      if (push) begin
         mem_q[wptr_q] <= wr_data;
      end
   end
endmodule

// file: core/lvtx_serializer.sv
// Soft serial transmitter: start-up sequencer, FIFO and MSB-first shifter.
`timescale 1ns/1ps
`include "lvtx_params.svh"
module lvtx_serializer #(
   parameter int unsigned FACTOR          = `LVTX_FACTOR,
   parameter int unsigned FIFO_DEPTH      = `LVTX_FIFO_DEPTH,
   parameter bit          USE_EXT_PLL     = 1'b0,
   parameter logic [1:0]  SWING           = `LVTX_SWING_HIGH,
   parameter int unsigned LOCK_ACQ_CYC    = `LVTX_LOCK_ACQ_CYC,
   parameter int unsigned LOCK_STABLE_CYC = `LVTX_LOCK_STABLE_CYC
) (
   // System clock and reset.
   input  wire logic              sys_clk,
   input  wire logic              rst_n,
   // Parallel words from the fabric.
   input  wire logic [FACTOR-1:0] in_data,
   input  wire logic              in_valid,
   output logic                   in_ready,
   // External PLL clocks and lock, used only with USE_EXT_PLL; the PLL reset drives out in both modes.
   input  wire logic              ext_bit_clk,
   input  wire logic              ext_word_clk,
   input  wire logic              ext_pll_locked,
   output logic                   pll_areset,
   // Serial differential output and its static swing code.
   output logic                   tx_out_p,
   output logic                   tx_out_n,
   output logic [1:0]             output_swing_setting,
   // Status.
   output lvtx_pkg::lvtx_status_t status
);
   import lvtx_pkg::*;

   localparam int unsigned CW = $clog2(FACTOR + 1);
   localparam logic [15:0] RST_CYC = 16'(`LVTX_PLL_RST_CYC);
   localparam logic [15:0] ACQ_CYC = 16'(LOCK_ACQ_CYC);
   localparam logic [15:0] STB_CYC = 16'(LOCK_STABLE_CYC);

   // The swing is a build-time choice; nothing at run time alters it.
   assign output_swing_setting = SWING;

   // Reset synchroniser: asserts at once, releases after two edges.
   logic rst_s1_q, rst_s2_q;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_s1_q <= 1'b0;
         rst_s2_q <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_s2_q <= rst_s1_q;
      end
   end
   logic rst_int_n;
   assign rst_int_n = rst_s2_q;

   // External pins pass two flops; a third flop serves edge detection
   // so that nothing reads the first stage. The external clocks must be
   // well below half the system rate for their edges to be seen.
   logic [2:0] ext_s1_q, ext_s2_q, ext_s3_q; // {lock, word, bit}
   always_ff @(posedge sys_clk or negedge rst_int_n) begin
      if (!rst_int_n) begin
         ext_s1_q <= '0;
         ext_s2_q <= '0;
         ext_s3_q <= '0;
      end else begin
         ext_s1_q <= {ext_pll_locked, ext_word_clk, ext_bit_clk};
         ext_s2_q <= ext_s1_q;
         ext_s3_q <= ext_s2_q;
      end
   end
   logic ext_bit_rise, ext_word_rise, ext_lock;
   assign ext_bit_rise  = ext_s2_q[0] && !ext_s3_q[0];
   assign ext_word_rise = ext_s2_q[1] && !ext_s3_q[1];
   assign ext_lock      = ext_s2_q[2];

   // Start-up sequencer state.
   lvtx_state_t st_q, st_d;           // Sequencer state.
   logic [15:0] cnt_q, cnt_d;         // Reset pulse and settle counter.
   logic [15:0] acq_q, acq_d;         // Internal PLL acquisition timer.
   logic        areset_q, areset_d;   // PLL reset drive.
   logic        lock_w;               // Selected lock indication.
   logic        int_lock;             // Internal PLL model lock.

   // The internal PLL belongs to this instance alone; its lock is a
   // timer that starts once the reset pulse ends.
   assign int_lock = (acq_q == ACQ_CYC);
   assign lock_w   = USE_EXT_PLL ? ext_lock : int_lock;

   // Sequencer next values.
   always_comb begin
      st_d     = st_q;
      cnt_d    = cnt_q;
      acq_d    = acq_q;
      areset_d = 1'b0;
      // The acquisition timer runs while the PLL is out of reset.
      if (st_q != LVTX_ST_RESET && acq_q != ACQ_CYC) begin
         acq_d = acq_q + 16'h0001;
      end
      case (st_q)
         LVTX_ST_RESET: begin
            // Hold the PLL reset for the rounded-up least pulse.
            areset_d = 1'b1;
            if (cnt_q >= RST_CYC - 16'h0001) begin
               areset_d = 1'b0;
               st_d     = LVTX_ST_ACQUIRE;
               cnt_d    = '0;
               acq_d    = '0;
            end else begin
               cnt_d = cnt_q + 16'h0001;
            end
         end
         LVTX_ST_ACQUIRE: begin
            // Wait for the lock indication to rise.
            cnt_d = '0;
            if (lock_w) begin
               st_d = LVTX_ST_SETTLE;
            end
         end
         LVTX_ST_SETTLE: begin
            // Lock must hold unbroken before any data moves.
            if (!lock_w) begin
               st_d  = LVTX_ST_ACQUIRE;
               cnt_d = '0;
            end else if (cnt_q >= STB_CYC - 16'h0001) begin
               st_d = LVTX_ST_RUN;
            end else begin
               cnt_d = cnt_q + 16'h0001;
            end
         end
         LVTX_ST_RUN: begin
            // Losing lock stops the line and restarts the wait.
            if (!lock_w) begin
               st_d  = LVTX_ST_ACQUIRE;
               cnt_d = '0;
            end
         end
         default: begin
            st_d  = LVTX_ST_RESET;
            cnt_d = '0;
         end
      endcase
   end

   // Sequencer registers; the PLL reset is high throughout reset.
   always_ff @(posedge sys_clk or negedge rst_int_n) begin
      if (!rst_int_n) begin
         st_q     <= LVTX_ST_RESET;
         cnt_q    <= '0;
         acq_q    <= '0;
         areset_q <= 1'b1;
      end else begin
         st_q     <= st_d;
         cnt_q    <= cnt_d;
         acq_q    <= acq_d;
         areset_q <= areset_d;
      end
   end

   assign pll_areset        = areset_q;
   assign status.pll_locked = lock_w;
   assign status.ser_ready  = (st_q == LVTX_ST_RUN);

   // Word FIFO; the fabric stalls through in_ready when it is full.
   logic [FACTOR-1:0] fifo_data;
   logic              fifo_valid;
   logic              fifo_pop;
   lvtx_fifo #(
      .WIDTH (FACTOR),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk      (sys_clk),
      .rst_n    (rst_int_n),
      .wr_data  (in_data),
      .wr_valid (in_valid),
      .wr_ready (in_ready),
      .rd_data  (fifo_data),
      .rd_valid (fifo_valid),
      .rd_ready (fifo_pop)
   );

   // Shifter state.
   logic [FACTOR-1:0] sh_q, sh_d;     // Bits still to send, MSB aligned.
   logic [CW-1:0]     bits_q, bits_d; // Bits left in the current word.
   logic              wpend_q, wpend_d; // Word edge seen, load pending.
   logic              tx_q, tx_d;     // Serial line level.
   logic              bit_tick, load_req, running;
   logic [FACTOR-1:0] word;

   // Internally the bit clock is the system clock itself; externally it
   // is each synchronised rising edge of the bit clock pin.
   assign bit_tick = USE_EXT_PLL ? ext_bit_rise : 1'b1;
   // A word loads when the word clock says so: internally when the last
   // bit has gone, externally at the first bit tick after its edge.
   assign load_req = USE_EXT_PLL ? (wpend_q || ext_word_rise)
                                 : (bits_q == '0);
   assign running  = (st_q == LVTX_ST_RUN);
   // With no word waiting, an idle word of zeros goes out instead.
   assign word     = fifo_valid ? fifo_data : '0;
   assign fifo_pop = running && bit_tick && load_req && fifo_valid;

   // Shifter next values.
   always_comb begin
      sh_d    = sh_q;
      bits_d  = bits_q;
      tx_d    = tx_q;
      wpend_d = wpend_q || ext_word_rise;
      if (!running) begin
         // Nothing leaves the block until the sequencer is in RUN.
         sh_d    = '0;
         bits_d  = '0;
         tx_d    = `LVTX_IDLE_LEVEL;
         wpend_d = 1'b0;
      end else if (bit_tick) begin
         if (load_req) begin
            // The first bit on the line is the word's MSB.
            tx_d    = word[FACTOR-1];
            sh_d    = word << 1;
            bits_d  = CW'(FACTOR - 1);
            wpend_d = 1'b0;
         end else if (bits_q != '0) begin
            // One bit per bit clock, MSB side first.
            tx_d   = sh_q[FACTOR-1];
            sh_d   = sh_q << 1;
            bits_d = bits_q - 1'b1;
         end else begin
            // Word exhausted before the next word edge: hold idle.
            tx_d = `LVTX_IDLE_LEVEL;
         end
      end
   end

   // Shifter registers.
   always_ff @(posedge sys_clk or negedge rst_int_n) begin
      if (!rst_int_n) begin
         sh_q    <= '0;
         bits_q  <= '0;
         wpend_q <= 1'b0;
         tx_q    <= `LVTX_IDLE_LEVEL;
      end else begin
         sh_q    <= sh_d;
         bits_q  <= bits_d;
         wpend_q <= wpend_d;
         tx_q    <= tx_d;
      end
   end

   // The negative leg is the registered complement of the positive one.
   assign tx_out_p = tx_q;
   assign tx_out_n = ~tx_q;
endmodule

// file: dv/lvtx_props.sv
// Port checker of the soft serial transmitter, bound to its top module.
`timescale 1ns/1ps
module lvtx_props #(
   parameter int unsigned FACTOR          = 8,
   parameter logic [1:0]  SWING           = 2'h2,
   parameter bit          USE_EXT_PLL     = 1'b0,
   parameter int unsigned LOCK_ACQ_CYC    = 64,
   parameter int unsigned LOCK_STABLE_CYC = 16
) (
   // Clock and reset.
   input wire logic                   sys_clk,
   input wire logic                   rst_n,
   // Watched outputs.
   input wire logic                   in_ready,
   input wire logic                   pll_areset,
   input wire logic                   tx_out_p,
   input wire logic                   tx_out_n,
   input wire logic [1:0]             output_swing_setting,
   input wire lvtx_pkg::lvtx_status_t status
);
   import lvtx_pkg::*;
   // Margins allow for the sync flops in front of the sequencer.
   localparam int ACQ_MAX = LOCK_ACQ_CYC + 4;
   localparam int STB_MAX = LOCK_STABLE_CYC + 4;
   // The external word clock rate is not known here, so in that mode the
   // drain check only bounds the wait for a load at a thousand cycles.
   localparam int POP_MAX = USE_EXT_PLL ? 1000 : FACTOR + 2;
   logic [15:0] lock_cnt_q; // Cycles that lock has stood high.
   logic [15:0] lock_cnt_d; // Next value of the lock counter.

   // Count consecutive locked cycles.
   always_comb lock_cnt_d = status.pll_locked ? lock_cnt_q + 16'h1 : 16'h0;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) lock_cnt_q <= 16'h0;
      else lock_cnt_q <= lock_cnt_d;
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   property p_swing;
      output_swing_setting == SWING;
   endproperty
   a_swing: assert property (p_swing)
      else $error("swing code differs from its setting");
   property p_diff;
      tx_out_n == !tx_out_p;
   endproperty
   a_diff: assert property (p_diff)
      else $error("line halves are not complementary");
   property p_idle;
      !status.ser_ready && !$past(status.ser_ready) |-> !tx_out_p;
   endproperty
   a_idle: assert property (p_idle)
      else $error("line moved before the stages were ready");
   property p_rdy_lock;
      status.ser_ready |-> status.pll_locked;
   endproperty
   a_rdy_lock: assert property (p_rdy_lock)
      else $error("ready without lock");
   property p_settle;
      $rose(status.ser_ready) |-> lock_cnt_q >= LOCK_STABLE_CYC;
   endproperty
   a_settle: assert property (p_settle)
      else $error("ready before lock was stable");
   property p_areset_lock;
      pll_areset |-> !status.pll_locked;
   endproperty
   a_areset_lock: assert property (p_areset_lock)
      else $error("lock shown while the PLL is in reset");
   property p_acquire;
      $fell(pll_areset) |-> ##[1:ACQ_MAX] status.pll_locked;
   endproperty
   a_acquire: assert property (p_acquire)
      else $error("lock not acquired in time");
   property p_run;
      $rose(status.pll_locked) |-> ##[1:STB_MAX] status.ser_ready;
   endproperty
   a_run: assert property (p_run)
      else $error("stages not ready after lock settled");
   property p_hold_full;
      !in_ready && !status.ser_ready |=> !in_ready;
   endproperty
   a_hold_full: assert property (p_hold_full)
      else $error("FIFO drained before the stages were ready");
   property p_drain;
      status.ser_ready && !in_ready |-> ##[1:POP_MAX] in_ready;
   endproperty
   a_drain: assert property (p_drain)
      else $error("no word loaded within one word period");
endmodule

bind lvtx_serializer lvtx_props #(
   .FACTOR(FACTOR), .SWING(SWING), .LOCK_ACQ_CYC(LOCK_ACQ_CYC),
   .USE_EXT_PLL(USE_EXT_PLL),
   .LOCK_STABLE_CYC(LOCK_STABLE_CYC)
) u_props (
   .sys_clk(sys_clk), .rst_n(rst_n), .in_ready(in_ready),
   .pll_areset(pll_areset), .tx_out_p(tx_out_p), .tx_out_n(tx_out_n),
   .output_swing_setting(output_swing_setting), .status(status)
);

// file: dv/lvtx_rx_model.sv
// Behavioural model of the board receiver at the far end of the line.
`timescale 1ns/1ps
module lvtx_rx_model #(
   parameter int unsigned FACTOR = 8
) (
   // Bit clock and framing start.
   input wire logic sys_clk,
   input wire logic ready,
   // Differential line.
   input wire logic line_p,
   input wire logic line_n
);
   logic [FACTOR-1:0] shift_q;  // Bits gathered so far.
   logic              sync_q;   // Word boundary found.
   int                nbits;    // Bits in the current word.
   logic [FACTOR-1:0] words[$]; // Words received, oldest first.

   // A frame starts at the first high bit once the sender is ready, so
   // the first word sent must carry a set top bit.
   always @(posedge sys_clk) begin
      if (!ready) begin
         sync_q = 1'b0;
         nbits = 0;
      end else if (sync_q || (line_p && !line_n)) begin
         sync_q = 1'b1;
         shift_q = {shift_q[FACTOR-2:0], line_p && !line_n};
         nbits++;
         if (nbits == FACTOR) begin
            words.push_back(shift_q);
            nbits = 0;
         end
      end
   end
endmodule

// file: dv/tb_lvtx_serializer.sv
// Self-checking bench of the soft serial transmitter.
`timescale 1ns/1ps
module tb_lvtx_serializer;
   import lvtx_pkg::*;
   logic         sys_clk;
   logic         rst_n;
   logic         in_valid;
   logic         in_ready;
   logic [7:0]   in_data;
   logic         pll_areset;
   logic         tx_out_p;
   logic         tx_out_n;
   logic [1:0]   swing;
   lvtx_status_t status;
   int           bad_count;
   int           total_checks;
   logic         pll_fast_output; // External bit clock.
   logic         pll_slow_output; // External word clock.
   logic         rx_clk;          // Board receiver's copy of the bit clock.
   logic         ext_lock;        // External PLL lock.
   int           ext_acq;         // External PLL lock timer.
   logic         ext_areset;      // PLL reset from the external-PLL copy.
   logic         in_ready_ext;
   logic         tx_ext_p;
   logic         tx_ext_n;
   logic [1:0]   swing_ext;
   lvtx_status_t status_ext;

   // Short lock times keep the run brief; external clock pins unused.
   lvtx_serializer #(.LOCK_ACQ_CYC(32), .LOCK_STABLE_CYC(8)) DUT (
      .sys_clk(sys_clk), .rst_n(rst_n), .in_data(in_data),
      .in_valid(in_valid), .in_ready(in_ready), .ext_bit_clk(1'b0),
      .ext_word_clk(1'b0), .ext_pll_locked(1'b0),
      .pll_areset(pll_areset), .tx_out_p(tx_out_p), .tx_out_n(tx_out_n),
      .output_swing_setting(swing), .status(status));
   lvtx_rx_model rx (.sys_clk(sys_clk), .ready(status.ser_ready),
      .line_p(tx_out_p), .line_n(tx_out_n));

   // Second copy runs from the external PLL model with the low swing.
   lvtx_serializer #(.USE_EXT_PLL(1'b1), .SWING(2'h0),
      .LOCK_ACQ_CYC(32), .LOCK_STABLE_CYC(8)) DUT_EXT (
      .sys_clk(sys_clk), .rst_n(rst_n), .in_data(in_data),
      .in_valid(in_valid), .in_ready(in_ready_ext),
      .ext_bit_clk(pll_fast_output), .ext_word_clk(pll_slow_output),
      .ext_pll_locked(ext_lock), .pll_areset(ext_areset),
      .tx_out_p(tx_ext_p), .tx_out_n(tx_ext_n),
      .output_swing_setting(swing_ext), .status(status_ext));
   lvtx_rx_model rx_ext (.sys_clk(rx_clk), .ready(status_ext.ser_ready),
      .line_p(tx_ext_p), .line_n(tx_ext_n));

   task automatic check(logic [7:0] seen, logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask

   task automatic stop_test();
      $display("checks %0d, mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // Inputs change a fixed 10 ns after each rising edge.
   task automatic tick(int n);
      repeat (n) @(posedge sys_clk);
      #10;
   endtask

   // Test word i; the first has its top bit set for receiver framing.
   function automatic logic [7:0] word(int i);
      return 8'(8'hc5 + 8'h13 * i);
   endfunction

   // Hold reset ten cycles and check the values shown meanwhile.
   task automatic t_reset();
      rst_n = 1'b0;
      tick(10);
      check({7'h0, pll_areset}, 8'h1);
      check({7'h0, tx_out_p}, 8'h0);
      check({7'h0, tx_out_n}, 8'h1);
      check({6'h0, status}, 8'h0);
      check({7'h0, in_ready}, 8'h1);
      check({6'h0, swing}, 8'h2);
      check({7'h0, ext_areset}, 8'h1);
      check({6'h0, swing_ext}, 8'h0);
      rst_n = 1'b1;
      rx.words.delete();
      rx_ext.words.delete();
   endtask

   // Fill the FIFO while the PLL locks, overfill it, then drain it.
   task automatic t_fill_drain();
      int n;
      tick(5);
      check({7'h0, pll_areset}, 8'h0);
      check({7'h0, ext_areset}, 8'h0);
      for (int i = 0; i < 16; i++) begin
         check({7'h0, in_ready}, 8'h1);
         in_valid = 1'b1;
         in_data = word(i);
         tick(1);
      end
      in_data = 8'hff;
      tick(3);
      in_valid = 1'b0;
      check({7'h0, in_ready}, 8'h0);
      check({7'h0, in_ready_ext}, 8'h0);
      check({7'h0, status.pll_locked}, 8'h0);
      n = 0;
      while (status.ser_ready !== 1'b1 && n < 200) begin
         tick(1);
         n++;
      end
      check({7'h0, status.ser_ready}, 8'h1);
      check({7'h0, status.pll_locked}, 8'h1);
      n = 0;
      while (rx.words.size() < 17 && n < 400) begin
         tick(1);
         n++;
      end
      check(8'(rx.words.size()), 8'h11);
      for (int i = 0; i < 16; i++)
         check(rx.words[i], word(i));
      check(rx.words[16], 8'h0);
   endtask

   // External clocks: the same sixteen words leave at the bit clock pace,
   // followed by an idle word once the FIFO has run dry.
   task automatic t_ext();
      int n;
      n = 0;
      while (rx_ext.words.size() < 17 && n < 800) begin
         tick(1);
         n++;
      end
      check({7'h0, status_ext.ser_ready}, 8'h1);
      check(8'(rx_ext.words.size()), 8'h11);
      for (int i = 0; i < 16; i++)
         check(rx_ext.words[i], word(i));
      check(rx_ext.words[16], 8'h0);
   endtask

   // Reset hits while a word of ones is on the line; the line must idle
   // at once. Waiting for a high bit keeps the final check meaningful.
   task automatic t_midrun();
      int n;
      in_valid = 1'b1;
      in_data = 8'hff;
      tick(1);
      in_valid = 1'b0;
      n = 0;
      while (tx_out_p !== 1'b1 && n < 20) begin
         tick(1);
         n++;
      end
      check({7'h0, tx_out_p}, 8'h1);
      rst_n = 1'b0;
      #1;
      check({7'h0, tx_out_p}, 8'h0);
      check({7'h0, pll_areset}, 8'h1);
   endtask

   // External PLL model: the fast output runs at a quarter of the system
   // rate and the slow output rises with every eighth fast edge, in phase
   // with it as source-synchronous compensation keeps them. The board
   // receiver gets its own copy so the fast output feeds only the block.
   initial begin
      pll_fast_output = 1'b0;
      pll_slow_output = 1'b0;
      rx_clk = 1'b0;
      forever begin
         for (int b = 0; b < 8; b++) begin
            tick(1);
            pll_fast_output = 1'b1;
            pll_slow_output = (b == 0);
            rx_clk = 1'b1;
            tick(2);
            pll_fast_output = 1'b0;
            rx_clk = 1'b0;
            @(posedge sys_clk);
         end
      end
   end

   // External PLL lock: returns twenty cycles after its reset ends and
   // drops within a cycle whenever that reset is raised again.
   initial begin
      ext_lock = 1'b0;
      ext_acq = 0;
      forever begin
         tick(1);
         if (ext_areset !== 1'b0) begin
            ext_acq = 0;
            ext_lock = 1'b0;
         end else if (ext_acq < 20) begin
            ext_acq++;
         end else begin
            ext_lock = 1'b1;
         end
      end
   end

   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end

   // Watchdog: the whole run needs about 1200 cycles.
   initial begin
      #(100 * 3000);
      bad_count++;
      stop_test();
   end

   initial begin
      rst_n = 1'b0;
      in_valid = 1'b0;
      in_data = 8'h0;
      bad_count = 0;
      total_checks = 0;
      t_reset();
      t_fill_drain();
      t_ext();
      t_midrun();
      t_reset();
      t_fill_drain();
      t_ext();
      stop_test();
   end
endmodule
